// ===== core/pcb_pkg.sv
package pcb_pkg;
	localparam int PC_W = 12;
	localparam int BANK_W = 2;
	localparam int BPTR_W = 4;
	localparam int FETCH_W = PC_W + BANK_W;
	localparam int ROM_DATA_W = 8;
	localparam int PAGE_LOW_W = 8;
	localparam logic [11:0] RESET_VEC = 12'h000;
	localparam logic [11:0] TIMER_VEC = 12'h004;
	localparam logic [11:0] RTC_VEC = 12'h008;
	localparam logic [3:0] LAST_PAGE = 4'hF;
	localparam logic [3:0] BPTR_RESET = 4'h0;
	localparam int BANK_LSB = 0;
	localparam int COND_KEEP_BIT = 11;

	typedef enum logic [3:0] {
		PCB_OP_NONE = 4'h0,
		PCB_OP_STEP1 = 4'h1,
		PCB_OP_STEP2 = 4'h2,
		PCB_OP_JUMP = 4'h3,
		PCB_OP_CALL = 4'h4,
		PCB_OP_COND = 4'h5,
		PCB_OP_RET = 4'h6,
		PCB_OP_RETI = 4'h7,
		PCB_OP_TBL_R4 = 4'h8,
		PCB_OP_TBL_MEM = 4'h9,
		PCB_OP_LTBL_R4 = 4'hA,
		PCB_OP_LTBL_MEM = 4'hB,
		PCB_OP_SET_BANK = 4'hC
	} pcb_op_t;

	typedef struct packed {
		pcb_op_t op;
		logic taken;
		logic [11:0] target;
		logic [7:0] low_addr;
		logic [3:0] acc;
	} pcb_cmd_t;

	typedef struct packed {
		logic valid;
		logic with_carry;
		logic [11:0] pc;
		logic carry;
	} pcb_push_t;

	typedef enum logic [1:0] {
		PCB_ST_FETCH = 2'b00,
		PCB_ST_TABLE = 2'b01
	} pcb_state_t;
endpackage

// ===== core/pcb_core.sv
// Functional notes
// - Twelve-bit instruction pointer within current bank
// - Pointer advances one or two per instruction
// - Reset fetches address zero of bank zero
// - Timer interrupt loads 004H, current bank
// - RTC interrupt loads 008H, current bank
// - Jump or call loads all twelve bits
// - Taken conditional branch keeps pointer bit eleven
// - Return reloads pointer from saved stack bits
// - Bank bits drive top two fetch bits
// - Bank pointer written only by its instruction
// - Bank pointer bits two, three unused
// - Bank select bits clear at reset
// - Eight-bit words, 4096 per bank
// - Table read: pointer page plus register low
// - Table byte goes to reg four or memory
// - Tables in current page or last page
// - Table page uses already incremented pointer
// - Interrupt saves pointer and carry; call pointer
`timescale 1ns/100ps
module pcb_core
	import pcb_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Decoder command
	input wire pcb_cmd_t cmd,
	input wire logic cmd_valid,
	input wire logic timer_irq,
	input wire logic rtc_irq,
	input wire logic carry_in,
	// Stack restore
	input wire logic [11:0] stack_pc,
	// Program ROM
	output logic [FETCH_W-1:0] fetch_addr,
	output logic fetch_is_table,
	input wire logic [ROM_DATA_W-1:0] rom_data,
	// Table result
	output logic tbl_valid,
	output logic tbl_to_mem,
	output logic [ROM_DATA_W-1:0] tbl_data,
	// Stack push and status
	output pcb_push_t push,
	output logic [PC_W-1:0] pc_out,
	output logic [BANK_W-1:0] bank_out
);
	logic [PC_W-1:0] pc_r;
	logic [PC_W-1:0] pc_nxt;
	logic [BPTR_W-1:0] bptr_r;
	logic [FETCH_W-1:0] fetch_addr_r;
	logic [FETCH_W-1:0] fetch_addr_nxt;
	logic fetch_is_table_r;
	logic tbl_pend_r;
	logic tbl_mem_r;
	logic tbl_valid_r;
	logic tbl_to_mem_r;
	logic [ROM_DATA_W-1:0] tbl_data_r;
	pcb_push_t push_r;
	pcb_state_t state_r;
	pcb_state_t state_nxt;

	function automatic logic is_table(input pcb_op_t op);
		is_table = (op == PCB_OP_TBL_R4) || (op == PCB_OP_TBL_MEM) ||
			(op == PCB_OP_LTBL_R4) || (op == PCB_OP_LTBL_MEM);
	endfunction

	function automatic logic is_last_page(input pcb_op_t op);
		is_last_page = (op == PCB_OP_LTBL_R4) || (op == PCB_OP_LTBL_MEM);
	endfunction

	// Bank bits come only from the low two pointer bits
	wire logic [BANK_W-1:0] bank = bptr_r[BANK_LSB +: BANK_W];
	wire logic [PC_W-1:0] pc_inc1 = pc_r + 12'h001;
	wire logic [PC_W-1:0] pc_inc2 = pc_r + 12'h002;
	wire logic do_irq = cmd_valid && (rtc_irq || timer_irq);
	wire logic bank_wr = (state_r == PCB_ST_FETCH) && cmd_valid && !do_irq && (cmd.op == PCB_OP_SET_BANK);
	// The fetch after a bank switch must already use the new bank
	wire logic [BANK_W-1:0] bank_nxt = bank_wr ? cmd.acc[BANK_LSB +: BANK_W] : bank;

	// Interrupts outrank the command in the same cycle; RTC wins over timer
	always_comb begin
		pc_nxt = pc_r;
		if (do_irq) begin
			pc_nxt = rtc_irq ? RTC_VEC : TIMER_VEC;
		end else if (cmd_valid) begin
			case (cmd.op)
				PCB_OP_STEP1: pc_nxt = pc_inc1;
				PCB_OP_STEP2: pc_nxt = pc_inc2;
				PCB_OP_JUMP, PCB_OP_CALL: pc_nxt = cmd.target;
				PCB_OP_COND: begin
					if (cmd.taken) begin
						pc_nxt = {pc_r[COND_KEEP_BIT], cmd.target[COND_KEEP_BIT-1:0]};
					end else begin
						pc_nxt = pc_inc2;
					end
				end
				PCB_OP_RET, PCB_OP_RETI: pc_nxt = stack_pc;
				PCB_OP_TBL_R4, PCB_OP_TBL_MEM, PCB_OP_LTBL_R4, PCB_OP_LTBL_MEM: pc_nxt = pc_inc1;
				PCB_OP_SET_BANK: pc_nxt = pc_inc1;
				default: pc_nxt = pc_r;
			endcase
		end
	end

	always_comb begin
		state_nxt = PCB_ST_FETCH;
		fetch_addr_nxt = {bank_nxt, pc_nxt};
		case (state_r)
			PCB_ST_FETCH: begin
				if (cmd_valid && !do_irq && is_table(cmd.op)) begin
					state_nxt = PCB_ST_TABLE;
					// Page taken from the incremented pointer, so a read at a page end looks ahead
					if (is_last_page(cmd.op)) begin
						fetch_addr_nxt = {bank, LAST_PAGE, cmd.low_addr};
					end else begin
						fetch_addr_nxt = {bank, pc_nxt[PC_W-1:PAGE_LOW_W], cmd.low_addr};
					end
				end
			end
			PCB_ST_TABLE: state_nxt = PCB_ST_FETCH;
			default: state_nxt = PCB_ST_FETCH;
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pc_r <= RESET_VEC;
		end else if (state_r == PCB_ST_FETCH) begin
			pc_r <= pc_nxt;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			bptr_r <= BPTR_RESET;
		end else if (bank_wr) begin
			bptr_r <= cmd.acc;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_r <= PCB_ST_FETCH;
			fetch_addr_r <= {BANK_W'(0), RESET_VEC};
			fetch_is_table_r <= 1'b0;
			tbl_pend_r <= 1'b0;
			tbl_mem_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			// Table cycle stalls the pointer, so the ROM port serves the table address once
			if (state_r == PCB_ST_FETCH) begin
				fetch_addr_r <= fetch_addr_nxt;
				fetch_is_table_r <= (state_nxt == PCB_ST_TABLE);
				tbl_pend_r <= (state_nxt == PCB_ST_TABLE);
				tbl_mem_r <= (cmd.op == PCB_OP_TBL_MEM) || (cmd.op == PCB_OP_LTBL_MEM);
			end else begin
				fetch_addr_r <= {bank, pc_r};
				fetch_is_table_r <= 1'b0;
				tbl_pend_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tbl_valid_r <= 1'b0;
			tbl_to_mem_r <= 1'b0;
			tbl_data_r <= 8'h00;
		end else begin
			tbl_valid_r <= tbl_pend_r;
			if (tbl_pend_r) begin
				tbl_data_r <= rom_data;
				tbl_to_mem_r <= tbl_mem_r;
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			push_r <= '0;
		end else begin
			push_r.valid <= (state_r == PCB_ST_FETCH) && (do_irq || (cmd_valid && cmd.op == PCB_OP_CALL));
			push_r.with_carry <= do_irq;
			push_r.carry <= do_irq ? carry_in : 1'b0;
			// Interrupt resumes at the instruction it preempted
			push_r.pc <= do_irq ? pc_r : pc_inc2;
		end
	end

	assign fetch_addr = fetch_addr_r;
	assign fetch_is_table = fetch_is_table_r;
	assign tbl_valid = tbl_valid_r;
	assign tbl_to_mem = tbl_to_mem_r;
	assign tbl_data = tbl_data_r;
	assign push = push_r;
	assign pc_out = pc_r;
	assign bank_out = bptr_r[BANK_LSB +: BANK_W];
endmodule

// ===== dv/pcb_rom.sv
`timescale 1ns/100ps
module pcb_rom (
	input wire logic [13:0] fetch_addr,
	output logic [7:0] rom_data
);
	// Bank and page bits fold into the word, so a wrong page reads a different byte
	assign rom_data = fetch_addr[7:0] ^ fetch_addr[13:6];
endmodule

// ===== dv/pcb_chk_sva.sv
`timescale 1ns/100ps
module pcb_chk import pcb_pkg::*; (
	input wire logic clock, rstn, cmd_valid, timer_irq, rtc_irq, fetch_is_table, tbl_valid,
	input wire pcb_cmd_t cmd,
	input wire logic [11:0] stack_pc, pc_out,
	input wire logic [13:0] fetch_addr,
	input wire logic [1:0] bank_out
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	logic busy_r;
	wire take = cmd_valid & !busy_r;
	wire go = take & !timer_irq & !rtc_irq;
	wire tb = go & cmd.op[3:2] == 2'b10;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) busy_r <= 1'b0;
		else busy_r <= tb;
	end
	rtc_vec_a: assert property (take & rtc_irq |=> pc_out == RTC_VEC) else $error("rtc");
	tmr_vec_a: assert property (take & timer_irq & !rtc_irq |=> pc_out == TIMER_VEC) else $error("tmr");
	jump_load_a: assert property (go & cmd.op == PCB_OP_JUMP |=> pc_out == $past(cmd.target)) else $error("jmp");
	cond_keep_a: assert property (go & cmd.op == PCB_OP_COND & cmd.taken |=> $stable(pc_out[11])) else $error("cond");
	ret_load_a: assert property (go & cmd.op == PCB_OP_RET |=> pc_out == $past(stack_pc)) else $error("ret");
	fetch_map_a: assert property (!fetch_is_table |-> fetch_addr == {bank_out, pc_out}) else $error("map");
	bank_only_a: assert property ($changed(bank_out) |-> $past(go & cmd.op == PCB_OP_SET_BANK)) else $error("bnk");
	table_read_a: assert property (tb |=> fetch_is_table ##1 tbl_valid & !fetch_is_table) else $error("tbl");
	cover property (tb);
	cover property (take & rtc_irq);
	cover property (go & cmd.op == PCB_OP_SET_BANK);
endmodule
bind pcb_core pcb_chk pcb_chk_inst (.*);

// ===== dv/testbench.sv
`timescale 1ns/100ps
module testbench import pcb_pkg::*;;
	logic clock = 0, rstn = 0, cmd_valid = 0, timer_irq = 0, rtc_irq = 0, carry_in = 0, ok = 1;
	logic fetch_is_table, tbl_valid, tbl_to_mem;
	logic [1:0] bank_out, e_bank = 0;
	logic [7:0] rom_data, tbl_data;
	logic [11:0] stack_pc = 0, pc_out, e_pc = 0, p_pc = 0;
	logic [13:0] fetch_addr, ta;
	logic [31:0] seed = 32'h837E;
	pcb_cmd_t cmd = 0;
	pcb_push_t push;
	int mismatches = 0, total_checks = 0, cyc = 0;
	always #12.5 clock = ~clock;
	pcb_core pcb_core_inst (.*);
	pcb_rom pcb_rom_inst (.*);
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	task automatic chk(input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t %h %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			print_verdict;
		end
	end
	// Table reads wait out their extra cycle, since a command there is ignored
	task automatic ex(input pcb_op_t op, input logic [11:0] t, input logic [7:0] lo,
		input logic [3:0] ac, input logic ti, ri);
		@(posedge clock);
		cmd <= '{op, lo[7], t, lo, ac};
		p_pc = e_pc;
		{cmd_valid, timer_irq, rtc_irq, stack_pc, carry_in} <= {1'b1, ti, ri, lo, ac, ac[0]};
		case (op)
			PCB_OP_JUMP, PCB_OP_CALL: e_pc = t;
			PCB_OP_COND: e_pc = lo[7] ? {e_pc[11], t[10:0]} : e_pc + 12'h002;
			PCB_OP_RET, PCB_OP_RETI: e_pc = {lo, ac};
			PCB_OP_STEP2: e_pc += 12'h002;
			default: e_pc += 12'h001;
		endcase
		if (ti | ri) e_pc = ri ? RTC_VEC : TIMER_VEC;
		else if (op == PCB_OP_SET_BANK) e_bank = ac[1:0];
		ok = ti | ri | op != PCB_OP_SET_BANK;
		ta = {e_bank, op[1] ? LAST_PAGE : e_pc[11:8], lo};
		@(posedge clock);
		{cmd_valid, timer_irq, rtc_irq} <= 0;
		#1;
		chk({bank_out, push}, {e_bank, ti | ri | op == PCB_OP_CALL, ti | ri, (ti | ri) ? p_pc : p_pc + 12'h002,
			(ti | ri) & ac[0]});
		if (!(ti | ri) & op[3:2] == 2'b10) begin
			chk(fetch_addr, ta);
			@(posedge clock);
			#1;
			chk({tbl_valid, tbl_to_mem, tbl_data}, {1'b1, op[0], ta[7:0] ^ ta[13:6]});
		end
		chk({pc_out, fetch_addr}, {e_pc, e_bank, e_pc});
	endtask
	initial begin
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		#1;
		chk(fetch_addr, 0);
		ex(PCB_OP_SET_BANK, 0, 0, 4'hE, 0, 0);
		ex(PCB_OP_JUMP, 12'h1FF, 0, 0, 0, 0);
		ex(PCB_OP_TBL_R4, 0, 8'h34, 0, 0, 0);
		ex(PCB_OP_LTBL_MEM, 0, 8'h5A, 0, 0, 0);
		ex(PCB_OP_JUMP, 12'h8FF, 0, 0, 0, 0);
		ex(PCB_OP_COND, 12'h0AB, 8'h80, 0, 0, 0);
		repeat (400) begin
			seed = xs(seed);
			ex(ok ? pcb_op_t'(seed[3:0] % 12 + 1) : PCB_OP_JUMP, seed[15:4], seed[23:16], seed[27:24],
				ok & seed[31:29] == 0, ok & seed[30:28] == 0);
		end
		print_verdict;
	end
endmodule
